/* logic/sarcv_cfg.svh */
// Timing and width constants for the serial converter readout block
`ifndef SARCV_CFG_SVH
`define SARCV_CFG_SVH
`define SARCV_RES_BITS 12
`define SARCV_CLK_MHZ 100
`define SARCV_CONVERT_STROBE_NS 1500
`define SARCV_CONVERT_STROBE_CYC ((`SARCV_CONVERT_STROBE_NS * `SARCV_CLK_MHZ + 999) / 1000)
`define SARCV_ACQ_NS 500
`define SARCV_ACQ_CYC ((`SARCV_ACQ_NS * `SARCV_CLK_MHZ + 999) / 1000)
`endif

/* logic/sarcv_pkg.sv */
// Types for the serial converter readout block
`default_nettype none
package sarcv_pkg;
    typedef enum logic [1:0] {
        SARCV_SLEEP,
        SARCV_ACQUIRE,
        SARCV_CONVERT
    } sarcv_state_t;
endpackage
`default_nettype wire

/* logic/sarcv_sar.sv */
// Successive approximation engine paced by a step enable
`timescale 1ns/1ps
`default_nettype none
module sarcv_sar #(
    parameter int WIDTH = 12
) (
    input wire logic i_clock, // System clock
    input wire logic i_nrst, // Synchronous reset, active low
    input wire logic i_start, // Begin a new approximation
    input wire logic i_step, // Advance one bit trial
    input wire logic [WIDTH-1:0] i_held, // Held sample value
    output logic o_done, // One-cycle pulse at completion
    output logic [WIDTH-1:0] o_result // Final code
);
    // Refuse widths the trial registers cannot serve
    if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
        $error("sarcv_sar width out of range");
    end
    logic [WIDTH-1:0] trial_ff, nxt_trial; // Code under trial
    logic [WIDTH-1:0] bit_ff, nxt_bit; // Bit currently tested
    logic busy_ff, nxt_busy; // Approximation running
    logic done_ff, nxt_done; // Completion pulse
    logic [WIDTH-1:0] res_ff, nxt_res; // Latched result
    logic [WIDTH-1:0] cand; // Trial with current bit kept

    // Next-state of the bit trial sequence
    always_comb begin
        cand = trial_ff | bit_ff;
        nxt_trial = trial_ff;
        nxt_bit = bit_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_res = res_ff;
        if (i_start) begin
            // Restart at the top bit
            nxt_trial = '0;
            nxt_bit = {1'b1, {(WIDTH-1){1'b0}}};
            nxt_busy = 1'b1;
        end else if (busy_ff && i_step) begin
            // Keep the bit when the trial does not exceed the sample
            if (cand <= i_held) begin
                nxt_trial = cand;
            end
            nxt_bit = bit_ff >> 1;
            if (bit_ff[0]) begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_res = (cand <= i_held) ? cand : trial_ff;
            end
        end
    end

    // Register the engine state
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            trial_ff <= '0;
            bit_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            res_ff <= '0;
        end else begin
            trial_ff <= nxt_trial;
            bit_ff <= nxt_bit;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            res_ff <= nxt_res;
        end
    end

    assign o_done = done_ff;
    assign o_result = res_ff;
endmodule
`default_nettype wire

/* logic/sarcv_top.sv */
// Convert control and serial result readout of a sampling converter
// Notes on behaviour
// - Convert strobe rising edge starts conversion
// - Conversion timed internally, not by shift clock
// - Twelve-bit successive approximation on held sample
// - Power down automatically after conversion
// - Output driven only while strobe low
// - Output changes only on shift clock falls and strobe falls
// - Result shifted out most significant first
// - Twelve result bits then zeros
// - Strobe fall enables driver, presents top bit
// - Zeros continue while strobe stays low
// - Strobe low wakes sampling; host waits acquisition
`timescale 1ns/1ps
`include "sarcv_cfg.svh"
`default_nettype none
module sarcv_top #(
    parameter int RES_BITS = `SARCV_RES_BITS,
    parameter int CONVERT_STROBE_CYC = `SARCV_CONVERT_STROBE_CYC
) (
    input wire logic i_clock, // System clock, 100 MHz
    input wire logic i_nrst, // Synchronous reset, active low
    input wire logic i_convert_strobe, // Convert strobe pin
    input wire logic i_shift_clk, // Shift clock pin from host
    input wire logic [RES_BITS-1:0] i_analog_code, // Digitised input level
    output logic o_serial_result_out, // Serial data value
    output logic o_serial_result_oe, // Serial data driver enable
    output logic o_powered, // Converter active, not asleep
    output logic o_sampling, // Sample-and-hold tracking
    output logic o_result_ready // Result held for readout
);
    // Cycles per bit trial, an equal share of the conversion time
    localparam int STEP = CONVERT_STROBE_CYC / RES_BITS;
    // Refuse sizes the engine and the 16-bit pacing timer cannot serve
    if (RES_BITS < 2 || RES_BITS > 16 || CONVERT_STROBE_CYC < RES_BITS
        || STEP > 65536) begin : g_param_check
        $error("sarcv_top parameters out of range");
    end

    // Raw pin levels, strobe in bit 0 and shift clock in bit 1
    localparam int NPIN = 2; // Pins that need synchronising
    wire logic [NPIN-1:0] pin_in; // Raw pin levels
    wire logic [NPIN-1:0] pin_rise; // Accepted rising edges
    wire logic [NPIN-1:0] pin_fall; // Accepted falling edges
    wire logic cv_rise; // Strobe rose
    wire logic cv_fall; // Strobe fell
    wire logic sk_fall; // Shift clock fell
    assign pin_in = {i_shift_clk, i_convert_strobe};

    // Three-stage synchroniser and edge finder, one per pin
    for (genvar g = 0; g < NPIN; g++) begin : g_pin
        logic [2:0] sync_ff, nxt_sync; // Stage one sits in bit 0
        logic lvl_ff, nxt_lvl; // Accepted level
        logic agree; // Stages two and three match
        // Next values of the synchroniser
        always_comb begin
            nxt_sync = {sync_ff[1:0], pin_in[g]};
            agree = (sync_ff[1] == sync_ff[2]);
            nxt_lvl = lvl_ff;
            if (agree) begin
                // Level counts once stages two and three agree
                nxt_lvl = sync_ff[2];
            end
        end
        // Register the synchroniser, only stage two reads stage one
        always_ff @(posedge i_clock) begin
            if (!i_nrst) begin
                sync_ff <= 3'h0;
                lvl_ff <= 1'b0;
            end else begin
                sync_ff <= nxt_sync;
                lvl_ff <= nxt_lvl;
            end
        end
        // An edge is a change of the accepted level
        assign pin_rise[g] = agree && sync_ff[2] && !lvl_ff;
        assign pin_fall[g] = agree && !sync_ff[2] && lvl_ff;
    end
    assign cv_rise = pin_rise[0];
    assign cv_fall = pin_fall[0];
    assign sk_fall = pin_fall[1];

    // Control state, timer and output shifter
    sarcv_pkg::sarcv_state_t st_ff, nxt_st;
    logic [15:0] tmr_ff, nxt_tmr; // Bit trial pacing timer
    logic [RES_BITS-1:0] held_ff, nxt_held; // Held sample
    logic [RES_BITS-1:0] shreg_ff, nxt_shreg; // Output shift register
    logic [RES_BITS-1:0] result_ff, nxt_result; // Last result
    logic sdo_ff, nxt_sdo; // Serial data bit
    logic oe_ff, nxt_oe; // Driver enable
    logic pwr_ff, nxt_pwr; // Awake flag
    logic samp_ff, nxt_samp; // Tracking flag
    logic rdy_ff, nxt_rdy; // Result ready flag
    logic step, sar_start, sar_done; // Engine handshake
    logic [RES_BITS-1:0] sar_res; // Engine result

    // Bit trial engine, paced by the internal timer
    sarcv_sar #(
        .WIDTH(RES_BITS)
    ) u_sar (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_start(sar_start),
        .i_step(step),
        .i_held(held_ff),
        .o_done(sar_done),
        .o_result(sar_res)
    );

    // Next values of control and readout
    always_comb begin
        // Everything holds unless an event moves it
        nxt_st = st_ff;
        nxt_tmr = tmr_ff;
        nxt_held = held_ff;
        nxt_shreg = shreg_ff;
        nxt_result = result_ff;
        nxt_sdo = sdo_ff;
        nxt_oe = oe_ff;
        nxt_pwr = pwr_ff;
        nxt_samp = samp_ff;
        nxt_rdy = rdy_ff;
        // Engine strobes idle by default
        step = 1'b0;
        sar_start = 1'b0;
        // Sleep, acquire and convert in turn
        case (st_ff)
            sarcv_pkg::SARCV_SLEEP: begin
                // Wake into sampling on strobe fall, a lone rise starts nothing
                if (cv_fall) begin
                    nxt_st = sarcv_pkg::SARCV_ACQUIRE;
                    nxt_pwr = 1'b1;
                    nxt_samp = 1'b1;
                end
            end
            sarcv_pkg::SARCV_ACQUIRE: begin
                // Track input until strobe rises
                if (cv_rise) begin
                    nxt_st = sarcv_pkg::SARCV_CONVERT;
                    // Freeze the sample and start the engine
                    nxt_held = i_analog_code;
                    nxt_samp = 1'b0;
                    nxt_tmr = 16'h0000;
                    sar_start = 1'b1;
                end
            end
            sarcv_pkg::SARCV_CONVERT: begin
                // Internal timer paces trials
                if (tmr_ff == 16'(STEP - 1)) begin
                    nxt_tmr = 16'h0000;
                    step = 1'b1;
                end else begin
                    nxt_tmr = tmr_ff + 16'h0001;
                end
                // Result latched and converter powered down together
                if (sar_done) begin
                    nxt_st = sarcv_pkg::SARCV_SLEEP;
                    nxt_pwr = 1'b0;
                    nxt_result = sar_res;
                    nxt_rdy = 1'b1;
                end
            end
            default: begin
                // Unused encoding falls back to sleep
                nxt_st = sarcv_pkg::SARCV_SLEEP;
            end
        endcase
        // Output driver follows the strobe level
        if (cv_rise) begin
            nxt_oe = 1'b0;
            // A result finishing in this cycle stays ready
            if (!sar_done) begin
                nxt_rdy = 1'b0;
            end
        end else if (cv_fall) begin
            // Top bit shown at once, position reloaded
            nxt_oe = 1'b1;
            nxt_sdo = result_ff[RES_BITS-1];
            nxt_shreg = {result_ff[RES_BITS-2:0], 1'b0};
        end else if (oe_ff && sk_fall) begin
            // Next bit, zeros fill behind
            nxt_sdo = shreg_ff[RES_BITS-1];
            nxt_shreg = {shreg_ff[RES_BITS-2:0], 1'b0};
        end
    end

    // Register control and readout state
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            // Asleep with the driver off
            st_ff <= sarcv_pkg::SARCV_SLEEP;
            tmr_ff <= 16'h0000;
            held_ff <= '0;
            shreg_ff <= '0;
            result_ff <= '0;
            sdo_ff <= 1'b0;
            oe_ff <= 1'b0;
            pwr_ff <= 1'b0;
            samp_ff <= 1'b0;
            rdy_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            tmr_ff <= nxt_tmr;
            held_ff <= nxt_held;
            shreg_ff <= nxt_shreg;
            result_ff <= nxt_result;
            sdo_ff <= nxt_sdo;
            oe_ff <= nxt_oe;
            pwr_ff <= nxt_pwr;
            samp_ff <= nxt_samp;
            rdy_ff <= nxt_rdy;
        end
    end

    // Every output comes straight from a register
    assign o_serial_result_out = sdo_ff;
    assign o_serial_result_oe = oe_ff;
    assign o_powered = pwr_ff;
    assign o_sampling = samp_ff;
    assign o_result_ready = rdy_ff;
endmodule
`default_nettype wire

/* verification/sarcv_asserts.sv */
// Port checks for the converter readout
`timescale 1ns/1ps
`default_nettype none
module sarcv_chk #(
    parameter int RES_BITS = 12,
    parameter int CONVERT_STROBE_CYC = 150
) (
    input wire logic i_clock, // Clock
    input wire logic i_nrst, // Reset
    input wire logic i_convert_strobe, // Strobe
    input wire logic i_shift_clk, // Shift clock
    input wire logic [RES_BITS-1:0] i_analog_code, // Level
    input wire logic o_serial_result_out, // Data
    input wire logic o_serial_result_oe, // Enable
    input wire logic o_powered, // Awake
    input wire logic o_sampling, // Tracking
    input wire logic o_result_ready // Done
);
    logic [RES_BITS-1:0] start_ff; // Code at start
    logic [RES_BITS-1:0] res_ff; // Last result
    // Conversion span in cycles, from hold to power-down
    localparam int CONVERT_STROBE_MIN = (CONVERT_STROBE_CYC / RES_BITS) * RES_BITS;
    localparam int CONVERT_STROBE_MAX = CONVERT_STROBE_MIN + 4;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    // Expected result, start to done
    always_ff @(posedge i_clock) begin
        if (!i_nrst) begin
            start_ff <= '0;
            res_ff <= '0;
        end else begin
            if ($fell(o_sampling)) begin
                start_ff <= i_analog_code;
            end
            if ($rose(o_result_ready)) begin
                res_ff <= start_ff;
            end
        end
    end
    chk_oe_off_high: assert property (
        i_convert_strobe [*6] |-> !o_serial_result_oe) else $error("driver on");
    chk_oe_on_low: assert property (
        $fell(i_convert_strobe) ##1 !i_convert_strobe [*5] |-> o_serial_result_oe) else $error("driver off");
    chk_sdo_shift_fall: assert property (
        $changed(o_serial_result_out) && o_serial_result_oe && $past(o_serial_result_oe)
        |-> !$past(i_shift_clk, 3)) else $error("data moved");
    chk_msb_shown: assert property (
        $rose(o_serial_result_oe) |-> o_serial_result_out == res_ff[RES_BITS-1]) else $error("bad top bit");
    chk_done_sleep: assert property (
        $fell(o_powered) |-> $rose(o_result_ready)) else $error("no ready");
    chk_convert_strobe_time: assert property (
        $fell(o_sampling) |-> ##[CONVERT_STROBE_MIN:CONVERT_STROBE_MAX] $fell(o_powered)) else $error("bad length");
    chk_wake_tracks: assert property (
        $rose(o_powered) |-> o_sampling) else $error("no tracking");
    chk_wake_on_fall: assert property (
        $rose(o_powered) |-> !$past(i_convert_strobe, 3)) else $error("odd wake");
    cover property ($rose(o_result_ready));
    cover property ($rose(o_serial_result_oe));
    cover property ($fell(o_sampling));
endmodule
bind sarcv_top sarcv_chk #(.RES_BITS(RES_BITS), .CONVERT_STROBE_CYC(CONVERT_STROBE_CYC)) u_chk (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_convert_strobe(i_convert_strobe), .i_shift_clk(i_shift_clk),
    .i_analog_code(i_analog_code), .o_serial_result_out(o_serial_result_out),
    .o_serial_result_oe(o_serial_result_oe), .o_powered(o_powered), .o_sampling(o_sampling),
    .o_result_ready(o_result_ready));
`default_nettype wire

/* verification/sarcv_host.sv */
// Host model driving strobe and shift clock
`timescale 1ns/1ps
`include "sarcv_cfg.svh"
`default_nettype none
module sarcv_host (
    input wire logic i_clock, // Clock
    input wire logic i_sdo, // Data
    input wire logic i_oe, // Enable
    output logic o_strobe, // Strobe
    output logic o_shift_clk // Shift clock
);
    wire logic line; // Wire level
    // Released line shows inverse
    assign line = i_oe ? i_sdo : ~i_sdo;
    initial begin
        o_strobe = 1'b1;
        o_shift_clk = 1'b1; // Still between frames
    end
    // Convert after acquisition
    task automatic convert();
        repeat (`SARCV_ACQ_CYC) @(posedge i_clock);
        o_strobe <= 1'b1;
        repeat (`SARCV_CONVERT_STROBE_CYC + 10) @(posedge i_clock);
    endtask
    // Wake and clock n bits in
    task automatic read(input int n, output logic [31:0] d);
        d = '0;
        @(posedge i_clock);
        o_strobe <= 1'b0;
        repeat (6) @(posedge i_clock);
        #1 d[31] = line;
        for (int i = 1; i < n; i++) begin
            @(posedge i_clock);
            o_shift_clk <= 1'b0;
            repeat (4) @(posedge i_clock);
            o_shift_clk <= 1'b1;
            #1 d[31-i] = line;
            repeat (3) @(posedge i_clock);
        end
    endtask
endmodule
`default_nettype wire

/* verification/sarcv_tb.sv */
// Bench for the converter readout
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_clock = 1'b0; // Clock
    logic i_nrst = 1'b0; // Reset
    logic [11:0] code = 12'h000; // Input level
    wire logic strobe, sck, serial_result_out, oe, pwr, smp, rdy; // Pins
    int miscompares = 0; // Mismatches
    int checks = 0; // Comparisons
    always #5 i_clock = ~i_clock;
    sarcv_host host (.i_clock(i_clock), .i_sdo(serial_result_out), .i_oe(oe), .o_strobe(strobe), .o_shift_clk(sck));
    sarcv_top uut (.i_clock(i_clock), .i_nrst(i_nrst), .i_convert_strobe(strobe), .i_shift_clk(sck),
        .i_analog_code(code), .o_serial_result_out(serial_result_out), .o_serial_result_oe(oe), .o_powered(pwr),
        .o_sampling(smp), .o_result_ready(rdy));
    // Compare and report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %h vs %h", $time, seen, exp);
        end
    endtask
    // Verdict and end
    task automatic summarize();
        if (miscompares == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Read n bits of prev, then convert nxt
    task automatic t_frame(input int n, input logic [11:0] prev, input logic [11:0] nxt);
        logic [31:0] d;
        host.read(n, d);
        check(d, {prev, 20'h0} & ~(32'hFFFFFFFF >> n));
        code <= nxt;
        @(negedge i_clock);
        check({29'h0, pwr, smp, oe}, 32'h7);
        host.convert();
        @(negedge i_clock);
        check({29'h0, pwr, rdy, oe}, 32'h2);
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clock);
        i_nrst <= 1'b1;
        // Let the pin synchronisers fill before the first strobe fall
        repeat (8) @(posedge i_clock);
        t_frame(32, 12'h000, 12'hA5C);
        t_frame(3, 12'hA5C, 12'hFFF);
        t_frame(16, 12'hFFF, 12'h001);
        t_frame(32, 12'h001, 12'h800);
        t_frame(12, 12'h800, 12'h000);
        summarize();
    end
    // Watchdog
    initial begin
        repeat (10000) @(posedge i_clock);
        miscompares++;
        summarize();
    end
endmodule
`default_nettype wire
